// [design/sap_pkg.sv]
// Shared constants for the serial converter port
package sap_pkg;
    localparam int          RES_W         = 8;
    localparam int          CMD_W         = 4;
    localparam logic [2:0]  CMD_LAST      = 3'h3;
    localparam logic [2:0]  MUX_EN_FALL   = 3'h5;
    localparam logic [2:0]  FIX_EN_FALL   = 3'h1;
    localparam logic [3:0]  SENT_SAT      = 4'hf;
    localparam logic        RST_SCLK      = 1'b0;
    localparam logic        RST_SDO       = 1'b0;
    localparam logic [7:0]  RST_RESULT    = 8'h00;
    typedef enum logic [2:0] {
        SAP_IDLE,
        SAP_WAIT_START,
        SAP_CMD,
        SAP_ACQ,
        SAP_SHIFT
    } sap_state_e;
endpackage : sap_pkg

// [design/sap_edge.sv]
// Shift clock edge detector on the system clock
`timescale 1ns/1ps
module sap_edge
    import sap_pkg::*;
(
    input  wire logic clock_i,
    input  wire logic rstn_i,
    input  wire logic sclk_i,
    output logic      rise_o,
    output logic      fall_o
);
    logic sclk_prev;
    logic next_sclk_prev;

    always_comb begin
        next_sclk_prev = sclk_i;
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sclk_prev <= RST_SCLK;
        end else begin
            sclk_prev <= next_sclk_prev;
        end
    end

    assign rise_o = sclk_i & ~sclk_prev;
    assign fall_o = ~sclk_i & sclk_prev;
endmodule : sap_edge

// [design/sap_port.sv]
// Serial control and result port of an 8-bit sampling converter
//
// Summary of operation
// [R01] Low select enables; high powers mux core down
// [R02] Falling select begins a new transfer
// [R03] Fixed variant drives output on first clock
// [R04] Two null bits precede the result
// [R05] Result MSB first, then zeros forever
// [R06] Select high resets serial state
// [R07] Mux variant samples input on rising clock
// [R08] Output changes on rising edge, host samples next
// [R09] Mux waits for start bit, takes 4 bits
// [R10] First two command bits set the multiplexer
// [R11] Last two bits give 2.5 clock acquisition; acquire_o lasts half a clock, 4th bit rise to next fall
// [R12] Fixed variant takes no command word
// [R13] Host runs 14.4MHz clock for fastest rate
// [R14] First one is start; later input ignored
// [R15] Bit one single-ended; bit two channel/polarity
// [R16] Shared wire: drive low on 5th fall
// [R17] Output high impedance while select high
`timescale 1ns/1ps
module sap_port
    import sap_pkg::*;
#(
    parameter bit IS_MUX = 1'b1
)(
    input  wire logic             clock_i,
    input  wire logic             rstn_i,
    input  wire logic             cs_n_i,
    input  wire logic             sclk_i,
    input  wire logic             sdi_i,
    input  wire logic [RES_W-1:0] conv_result_i,
    output logic                  sdo_o,
    output logic                  sdo_oe_o,
    output logic                  enable_o,
    output logic                  core_power_o,
    output logic                  single_or_differential_select_o,
    output logic                  channel_or_polarity_o,
    output logic                  acquire_o,
    output logic                  conv_start_o
);
    // ==========================================================
    // Shift clock edges
    logic sclk_rise;
    logic sclk_fall;

    sap_edge u_edge (
        .clock_i (clock_i),
        .rstn_i  (rstn_i),
        .sclk_i  (sclk_i),
        .rise_o  (sclk_rise),
        .fall_o  (sclk_fall)
    );

    // ==========================================================
    // Transfer sequencer
    sap_state_e       state,      next_state;
    logic [2:0]       fall_cnt,   next_fall_cnt;
    logic [2:0]       cmd_cnt,    next_cmd_cnt;
    logic             sel_single, next_sel_single;
    logic             sel_odd,    next_sel_odd;
    logic [RES_W-1:0] shreg,      next_shreg;
    logic             null_left,  next_null_left;
    logic             sdo,        next_sdo;
    logic             sdo_oe,     next_sdo_oe;
    logic             start,      next_start;
    logic [2:0]       en_fall;

    assign en_fall = IS_MUX ? MUX_EN_FALL : FIX_EN_FALL;

    always_comb begin
        next_state      = state;
        next_fall_cnt   = fall_cnt;
        next_cmd_cnt    = cmd_cnt;
        next_sel_single = sel_single;
        next_sel_odd    = sel_odd;
        next_shreg      = shreg;
        next_null_left  = null_left;
        next_sdo        = sdo;
        next_sdo_oe     = sdo_oe;
        next_start      = 1'b0;
        case (state)
            SAP_IDLE: begin
                next_fall_cnt = 3'h0;
                // A high select is overridden below, so only a low one begins a transfer
                next_state = IS_MUX ? SAP_WAIT_START : SAP_ACQ; // R02 R12
            end
            SAP_WAIT_START: begin
                // Leading zeros are skipped
                if (sclk_rise && sdi_i) begin // R07 R14
                    next_state    = SAP_CMD; // R09
                    next_cmd_cnt  = 3'h0;
                    next_fall_cnt = 3'h0;
                end
            end
            SAP_CMD: begin
                if (sclk_fall) begin
                    next_fall_cnt = fall_cnt + 3'h1;
                end
                if (sclk_rise) begin
                    if (cmd_cnt == 3'h0) begin
                        next_sel_single = sdi_i; // R10 R15
                    end
                    if (cmd_cnt == 3'h1) begin
                        next_sel_odd = sdi_i; // R10 R15
                    end
                    next_cmd_cnt = cmd_cnt + 3'h1;
                    // Dummy bits only pace the acquisition
                    if (cmd_cnt == CMD_LAST) begin
                        next_state = SAP_ACQ; // R11
                    end
                end
            end
            SAP_ACQ: begin
                if (sclk_fall) begin
                    if (fall_cnt + 3'h1 == en_fall) begin
                        next_state     = SAP_SHIFT;
                        next_sdo_oe    = 1'b1; // R03 R16
                        next_sdo       = 1'b0; // R04
                        next_shreg     = conv_result_i;
                        next_null_left = 1'b1; // R04
                        next_start     = 1'b1;
                    end else begin
                        next_fall_cnt = fall_cnt + 3'h1;
                    end
                end
            end
            SAP_SHIFT: begin
                if (sclk_rise) begin // R08
                    if (null_left) begin
                        next_null_left = 1'b0; // R04
                        next_sdo       = 1'b0;
                    end else begin
                        // Zero fill keeps output low after the LSB
                        next_sdo   = shreg[RES_W-1]; // R05
                        next_shreg = {shreg[RES_W-2:0], 1'b0}; // R05
                    end
                end
            end
            default: begin
                next_state = SAP_IDLE;
            end
        endcase
        // High select aborts anything in flight
        if (cs_n_i) begin // R06
            next_state     = SAP_IDLE;
            next_sdo_oe    = 1'b0; // R17
            next_sdo       = RST_SDO;
            next_null_left = 1'b0;
            next_cmd_cnt   = 3'h0;
            next_start     = 1'b0;
        end
        if (!IS_MUX) begin
            next_sel_single = 1'b0; // R12
            next_sel_odd    = 1'b0;
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state      <= SAP_IDLE;
            fall_cnt   <= 3'h0;
            cmd_cnt    <= 3'h0;
            sel_single <= 1'b0;
            sel_odd    <= 1'b0;
            shreg      <= RST_RESULT;
            null_left  <= 1'b0;
            sdo        <= RST_SDO;
            sdo_oe     <= 1'b0;
            start      <= 1'b0;
        end else begin
            state      <= next_state;
            fall_cnt   <= next_fall_cnt;
            cmd_cnt    <= next_cmd_cnt;
            sel_single <= next_sel_single;
            sel_odd    <= next_sel_odd;
            shreg      <= next_shreg;
            null_left  <= next_null_left;
            sdo        <= next_sdo;
            sdo_oe     <= next_sdo_oe;
            start      <= next_start;
        end
    end

    // ==========================================================
    // Outputs
    assign sdo_o                           = sdo;
    assign sdo_oe_o                        = sdo_oe;
    assign enable_o                        = ~cs_n_i; // R01
    // Fixed variant keeps its core powered between transfers
    assign core_power_o                    = IS_MUX ? ~cs_n_i : 1'b1; // R01
    assign single_or_differential_select_o = sel_single;
    assign channel_or_polarity_o           = sel_odd;
    assign acquire_o                       = (state == SAP_ACQ); // R11
    assign conv_start_o                    = start;

    // ==========================================================
    // Checks
    logic [3:0] sent_cnt;
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sent_cnt <= 4'h0;
        end else if (state != SAP_SHIFT) begin
            sent_cnt <= 4'h0;
        end else if (sclk_rise && sent_cnt != SENT_SAT) begin
            sent_cnt <= sent_cnt + 4'h1;
        end
    end

    AST_OE_OFF_CS_HIGH: assert property (@(posedge clock_i) // R17
        disable iff (!rstn_i) cs_n_i |=> !sdo_oe_o)
        else $error("output driven while select high");
    AST_RESET_ON_CS: assert property (@(posedge clock_i) // R06
        disable iff (!rstn_i) $rose(cs_n_i) |=> state == SAP_IDLE)
        else $error("serial state not reset on select high");
    AST_POWER_DOWN: assert property (@(posedge clock_i) // R01
        disable iff (!rstn_i) IS_MUX && cs_n_i |-> !core_power_o)
        else $error("mux core powered while deselected");
    AST_EN_ON_FALL: assert property (@(posedge clock_i) // R03
        disable iff (!rstn_i) $rose(sdo_oe_o) |-> $past(sclk_fall)
            && $past(acquire_o))
        else $error("output enabled off a falling edge");
    AST_NULL_BITS: assert property (@(posedge clock_i) // R04
        disable iff (!rstn_i)
        sdo_oe_o && state == SAP_SHIFT && sent_cnt < 4'h2 |-> !sdo_o)
        else $error("null bit not zero");
    AST_MSB_FIRST: assert property (@(posedge clock_i) // R05
        disable iff (!rstn_i) state == SAP_SHIFT && sclk_rise
            && !null_left && !cs_n_i |=> sdo_o == $past(shreg[RES_W-1]))
        else $error("result bit out of order");
    AST_ZERO_FILL: assert property (@(posedge clock_i) // R05
        disable iff (!rstn_i) sent_cnt > 4'h9 |-> !sdo_o)
        else $error("nonzero bit after result");
    AST_CHANGE_ON_RISE: assert property (@(posedge clock_i) // R08
        disable iff (!rstn_i) sdo_oe_o && $past(sdo_oe_o)
            && $changed(sdo_o) |-> $past(sclk_rise))
        else $error("output changed away from rising edge");
    AST_START_BIT: assert property (@(posedge clock_i) // R14
        disable iff (!rstn_i) state == SAP_WAIT_START && !cs_n_i
            && sclk_rise |=> (state == SAP_CMD) == $past(sdi_i))
        else $error("start bit handling wrong");
    AST_MUX_SAMPLE: assert property (@(posedge clock_i) // R15
        disable iff (!rstn_i) IS_MUX && state == SAP_CMD && !cs_n_i
            && sclk_rise && cmd_cnt == 3'h0
            |=> single_or_differential_select_o == $past(sdi_i))
        else $error("mode bit not sampled");
    AST_IGNORE_LATE: assert property (@(posedge clock_i) // R09
        disable iff (!rstn_i) state == SAP_SHIFT
            |=> $stable(channel_or_polarity_o))
        else $error("input taken after command word");
    AST_NEW_TRANSFER: assert property (@(posedge clock_i) // R02
        disable iff (!rstn_i) state == SAP_IDLE && !cs_n_i
            |=> state != SAP_IDLE)
        else $error("select low did not begin a transfer");
    AST_SELECT_RESET: assert property (@(posedge clock_i) // R06
        disable iff (!rstn_i) cs_n_i
            |=> state == SAP_IDLE && !conv_start_o)
        else $error("deselect did not clear the transfer");
    AST_OE_HOLD: assert property (@(posedge clock_i) // R05
        disable iff (!rstn_i) sdo_oe_o && !cs_n_i |=> sdo_oe_o)
        else $error("output released with select low");
    AST_START_PULSE: assert property (@(posedge clock_i) // R04
        disable iff (!rstn_i) conv_start_o
            |-> $rose(sdo_oe_o) && state == SAP_SHIFT)
        else $error("conversion start not with output enable");
    AST_START_ONCE: assert property (@(posedge clock_i) // R04
        disable iff (!rstn_i) conv_start_o |=> !conv_start_o)
        else $error("conversion start longer than one cycle");
    AST_ACQ_AFTER_CMD: assert property (@(posedge clock_i) // R11
        disable iff (!rstn_i) IS_MUX && $rose(acquire_o)
            |-> $past(sclk_rise) && $past(cmd_cnt) == CMD_LAST)
        else $error("acquisition not after the fourth command bit");
    AST_FIFTH_FALL: assert property (@(posedge clock_i) // R16
        disable iff (!rstn_i) IS_MUX && $rose(sdo_oe_o)
            |-> $past(fall_cnt) == MUX_EN_FALL - 3'h1)
        else $error("shared line not taken on the fifth fall");
    AST_MUX_ODD: assert property (@(posedge clock_i) // R10
        disable iff (!rstn_i) IS_MUX && state == SAP_CMD && !cs_n_i
            && sclk_rise && cmd_cnt == 3'h1
            |=> channel_or_polarity_o == $past(sdi_i))
        else $error("channel bit not sampled");
    AST_FIXED_NO_CMD: assert property (@(posedge clock_i) // R12
        disable iff (!rstn_i) !IS_MUX
            |-> state != SAP_WAIT_START && state != SAP_CMD)
        else $error("fixed variant waited for a command");
    AST_FIXED_SEL: assert property (@(posedge clock_i) // R12
        disable iff (!rstn_i) !IS_MUX
            |-> !single_or_differential_select_o && !channel_or_polarity_o)
        else $error("fixed variant select not differential");

    COV_FULL_RESULT: cover property (@(posedge clock_i)
        disable iff (!rstn_i) sent_cnt == 4'h9);
    COV_SINGLE_ENDED: cover property (@(posedge clock_i)
        disable iff (!rstn_i) $rose(sdo_oe_o)
            && single_or_differential_select_o);
    COV_ABORT: cover property (@(posedge clock_i)
        disable iff (!rstn_i) state == SAP_CMD && cs_n_i);
    COV_REVERSED_DIFF: cover property (@(posedge clock_i)
        disable iff (!rstn_i) $rose(sdo_oe_o)
            && !single_or_differential_select_o && channel_or_polarity_o);
    COV_ZERO_TAIL: cover property (@(posedge clock_i)
        disable iff (!rstn_i) sent_cnt == 4'ha);
endmodule : sap_port

// [test/sap_host.sv]
// Host-side serial master model: select, shift clock and command word
`timescale 1ns/1ps
// ==========================================================
// Host model
module sap_host (
    input  wire logic       clock_i,
    input  wire logic [1:0] sdo_i,
    input  wire logic [1:0] sdo_oe_i,
    output logic            cs_n_o,
    output logic            sclk_o,
    output logic            sdi_o
);
    logic [1:0] seen_d [0:31];
    logic [1:0] seen_e [0:31];

    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        sdi_o  = 1'b0;
    end

    task automatic select(input logic lvl);
        @(posedge clock_i);
        cs_n_o <= lvl;
    endtask : select

    // Clock stands still outside frames; 90 ns period stays under 14.4 MHz
    task automatic frame(input int lead, input logic [3:0] cmd, input int n);
        select(1'b0);
        for (int k = 0; k < n; k++) begin
            @(posedge clock_i);
            if (k < lead)
                sdi_o <= 1'b0;
            else if (k == lead)
                sdi_o <= 1'b1;
            else if (k <= lead + 4)
                sdi_o <= cmd[lead + 4 - k];
            else
                sdi_o <= ~sdi_o;
            repeat (3) @(posedge clock_i);
            @(negedge clock_i);
            // Taken just before the next rise, as a host would
            seen_d[k] = sdo_i;
            seen_e[k] = sdo_oe_i;
            @(posedge clock_i);
            sclk_o <= 1'b1;
            repeat (4) @(posedge clock_i);
            sclk_o <= 1'b0;
        end
        repeat (4) @(posedge clock_i);
        select(1'b1);
    endtask : frame
endmodule : sap_host

// [test/sap_port_bench.sv]
// Self-checking bench for both variants of the serial converter port
`timescale 1ns/1ps
// ==========================================================
// Bench top
module sap_port_bench
    import sap_pkg::*;
;
    logic             clock = 1'b0;
    logic             rstn  = 1'b0;
    logic             cs_n;
    logic             sclk;
    logic             sdi;
    logic [RES_W-1:0] result = 8'h00;
    wire  [1:0]       sdo;
    wire  [1:0]       oe;
    wire  [1:0]       en;
    wire  [1:0]       pwr;
    wire  [1:0]       sgl;
    wire  [1:0]       odd;
    wire  [1:0]       acq;
    wire  [1:0]       cst;
    int               starts [2]     = '{0, 0};
    int               acq_cycles [2] = '{0, 0};
    int               miscompares = 0;
    int               check_count = 0;

    initial begin
        forever #5 clock = ~clock;
    end

    sap_host i_host (.clock_i(clock), .sdo_i(sdo), .sdo_oe_i(oe),
        .cs_n_o(cs_n), .sclk_o(sclk), .sdi_o(sdi));

    // Index 0 is the multiplexed variant, index 1 the fixed one
    for (genvar g = 0; g < 2; g++) begin : g_var
        sap_port #(.IS_MUX(g == 0)) i_dut (
            .clock_i(clock), .rstn_i(rstn), .cs_n_i(cs_n),
            .sclk_i(sclk), .sdi_i(sdi), .conv_result_i(result),
            .sdo_o(sdo[g]), .sdo_oe_o(oe[g]), .enable_o(en[g]),
            .core_power_o(pwr[g]),
            .single_or_differential_select_o(sgl[g]),
            .channel_or_polarity_o(odd[g]), .acquire_o(acq[g]),
            .conv_start_o(cst[g]));
    end

    // Counted on the edge, so each one-cycle pulse counts once
    always @(posedge clock) begin
        for (int v = 0; v < 2; v++) begin
            if (cst[v] === 1'b1)
                starts[v] <= starts[v] + 1;
            if (acq[v] === 1'b1)
                acq_cycles[v] <= acq_cycles[v] + 1;
        end
    end

    task automatic check(input string what, input logic [7:0] exp,
                         input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic check_stream(input int lead, input logic [7:0] res,
                                input int n);
        int   j;
        logic e_bit;
        logic d_bit;
        logic x_bit;
        for (int v = 0; v < 2; v++) begin
            for (int k = 0; k < n; k++) begin
                j = k - ((v == 0) ? lead + 5 : 1);
                e_bit = i_host.seen_e[k][v];
                d_bit = i_host.seen_d[k][v];
                check("oe", {7'h0, j >= 0}, {7'h0, e_bit});
                if (j >= 0) begin
                    x_bit = j >= 2 && j < 10 && res[9 - j];
                    check("sdo", {7'h0, x_bit}, {7'h0, d_bit});
                end
            end
        end
    endtask : check_stream

    task automatic t_select();
        i_host.select(1'b0);
        repeat (2) @(posedge clock);
        @(negedge clock);
        check("enable", 8'h03, {6'h0, en});
        check("power", 8'h03, {6'h0, pwr});
        check("oe early", 8'h00, {6'h0, oe});
        i_host.select(1'b1);
    endtask : t_select

    task automatic t_codes();
        logic [7:0] res;
        int         s0;
        int         s1;
        int         a0;
        for (int c = 0; c < 4; c++) begin
            res = 8'h81 ^ (8'h42 * c[7:0]);
            @(posedge clock);
            result <= res;
            s0 = starts[0];
            s1 = starts[1];
            a0 = acq_cycles[0];
            fork
                i_host.frame(c, {c[1], c[0], ~c[0], c[1]}, c + 17);
                begin
                    repeat ((c + 7) * 9) @(posedge clock);
                    @(negedge clock);
                    check("single", {7'h0, c[1]}, {7'h0, sgl[0]});
                    check("chan", {7'h0, c[0]}, {7'h0, odd[0]});
                    check("fixed sel", 8'h00, {6'h0, sgl[1], odd[1]});
                end
            join
            check("mux start", 8'h01, 8'(starts[0] - s0));
            check("fixed start", 8'h01, 8'(starts[1] - s1));
            check("acquire", 8'h01, {7'h0, acq_cycles[0] > a0});
            check_stream(c, res, c + 17);
        end
    endtask : t_codes

    task automatic t_abort();
        int s0;
        int s1;
        int a0;
        s0 = starts[0];
        s1 = starts[1];
        a0 = acq_cycles[0];
        i_host.frame(0, 4'hf, 3);
        repeat (3) @(posedge clock);
        @(negedge clock);
        check("abort start", 8'h00, 8'(starts[0] - s0));
        check("fixed start", 8'h01, 8'(starts[1] - s1));
        check("abort acquire", 8'h00, {7'h0, acq_cycles[0] > a0});
        check("oe idle", 8'h00, {6'h0, oe});
        check("enable", 8'h00, {6'h0, en});
        check("power", 8'h02, {6'h0, pwr});
        @(posedge clock);
        result <= 8'h01;
        i_host.frame(2, 4'h4, 19);
        check_stream(2, 8'h01, 19);
    endtask : t_abort

    task automatic report_and_stop();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (16) @(posedge clock);
        rstn <= 1'b1;
        repeat (2) @(posedge clock);
        t_select();
        t_codes();
        t_abort();
        report_and_stop();
    end
endmodule : sap_port_bench
